// ---- mga_mic_gain_agc_control.sv ----
// Record-path microphone gain control with soft stepping and gain loop.
// Assumes ADC samples arrive on sample_valid in the clock domain.
`timescale 1ns/1ps
module mga_mic_gain_agc_control #(
  parameter int SAMPLE_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_page,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  output logic signed [SAMPLE_W-1:0] rec_data,
  output logic rec_valid,
  output logic [1:0] mic_bias_level,
  output logic [6:0] applied_gain,
  output logic microphone_gain_amp_muted,
  output logic signed [8:0] mic_effective_gain,
  output logic signed [8:0] first_auxiliary_input_gain,
  output logic signed [8:0] second_auxiliary_input_gain
);
  import mga_pkg::*;

  typedef enum logic {ST_NORMAL, ST_SILENCE} mga_agc_state_t;

  logic [7:0] bias_q, gain_ctrl_q, res_q, pwr_q, mute_q;
  logic [7:0] loop_q, hyst_q, max_q, attack_q, decay_q, ndb_q, sdb_q;
  logic [7:0] coef_q [COEF_REGS];
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [6:0] applied_q, req_gain, agc_gain_q;
  logic powered_q, half_q, tick;
  logic [15:0] tick_cnt_q;
  logic signed [SAMPLE_W-1:0] rec_q;
  logic rec_valid_q, rec_sat_q, loop_sat_q;
  logic [15:0] avg_q, xp_q, avg_d, target_lin, thr_lin, rel_lin;
  logic [16:0] ax;
  logic signed [34:0] acc;
  mga_agc_state_t st_q;
  logic [9:0] db_q;
  logic [7:0] rate_cnt_q;
  logic [8:0] gain_res [3];
  logic loop_en, sel_ctrl, sel_ana, sel_coef;
  mga_ss_t ss_mode;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  assign loop_en = loop_q[BIT_LOOP_EN];
  assign ss_mode = mga_ss_t'(pwr_q[1:0]);
  assign sel_ctrl = (reg_page == PAGE_CTRL);
  assign sel_ana = (reg_page == PAGE_ANALOG);
  assign sel_coef = (reg_page == PAGE_COEF);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bias_q <= RST_ZERO;
      gain_ctrl_q <= RST_MIC_GAIN_CTRL;
      res_q <= RST_ZERO;
      pwr_q <= RST_RECORD_POWER_SOFTSTEP;
      mute_q <= RST_RECORD_MUTE;
      loop_q <= RST_ZERO;
      hyst_q <= RST_ZERO;
      max_q <= RST_ZERO;
      attack_q <= RST_ZERO;
      decay_q <= RST_ZERO;
      ndb_q <= RST_ZERO;
      sdb_q <= RST_ZERO;
    end else if (reg_wr && sel_ana) begin
      if (reg_addr == OFS_MIC_BIAS_CTRL) bias_q <= reg_wdata;
      if (reg_addr == OFS_MIC_GAIN_CTRL) gain_ctrl_q <= reg_wdata;
      if (reg_addr == OFS_INPUT_RESISTANCE) res_q <= reg_wdata;
    end else if (reg_wr && sel_ctrl) begin
      if (reg_addr == OFS_RECORD_POWER_SOFTSTEP) pwr_q <= reg_wdata;
      if (reg_addr == OFS_RECORD_MUTE) mute_q <= reg_wdata;
      if (reg_addr == OFS_GAIN_LOOP_ENABLE_TARGET) loop_q <= reg_wdata;
      if (reg_addr == OFS_GAIN_LOOP_HYSTERESIS_THRESHOLD) hyst_q <= reg_wdata;
      if (reg_addr == OFS_GAIN_LOOP_MAX_GAIN) max_q <= reg_wdata;
      if (reg_addr == OFS_GAIN_LOOP_ATTACK) attack_q <= reg_wdata;
      if (reg_addr == OFS_GAIN_LOOP_DECAY) decay_q <= reg_wdata;
      if (reg_addr == OFS_NOISE_DEBOUNCE_TIME) ndb_q <= reg_wdata;
      if (reg_addr == OFS_SIGNAL_DEBOUNCE_TIME) sdb_q <= reg_wdata;
    end
  end

  // Coefficient bytes, high byte first per coefficient
  for (genvar i = 0; i < COEF_REGS; i++) begin : g_coef
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        coef_q[i] <= (i == 0) ? RST_COEF_HI0 : (i == 1) ? RST_COEF_LO0 : RST_ZERO;
      end else if (reg_wr && sel_coef && reg_addr == OFS_COEF_FIRST + 7'(i)) begin
        coef_q[i] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= RST_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= RST_ZERO;
        if (sel_ana) begin
          if (reg_addr == OFS_MIC_BIAS_CTRL) rdata_q <= bias_q;
          if (reg_addr == OFS_MIC_GAIN_CTRL) rdata_q <= gain_ctrl_q;
          if (reg_addr == OFS_INPUT_RESISTANCE) rdata_q <= res_q;
        end else if (sel_coef) begin
          for (int k = 0; k < COEF_REGS; k++) begin
            if (reg_addr == OFS_COEF_FIRST + 7'(k)) rdata_q <= coef_q[k];
          end
        end else if (sel_ctrl) begin
          if (reg_addr == OFS_RECORD_STATUS_FLAGS) begin
            rdata_q[BIT_SETTLED] <= (applied_q == req_gain);
            rdata_q[BIT_POWERED] <= powered_q;
            rdata_q[BIT_LOOP_SAT] <= loop_sat_q;
          end
          if (reg_addr == OFS_RECORD_SATURATION_STATUS) rdata_q[BIT_REC_SAT] <= rec_sat_q;
          if (reg_addr == OFS_NOISE_LEVEL_STATUS) rdata_q[BIT_ABOVE_NOISE] <= (st_q == ST_NORMAL);
          if (reg_addr == OFS_RECORD_POWER_SOFTSTEP) rdata_q <= pwr_q;
          if (reg_addr == OFS_RECORD_MUTE) rdata_q <= mute_q;
          if (reg_addr == OFS_GAIN_LOOP_ENABLE_TARGET) rdata_q <= loop_q;
          if (reg_addr == OFS_GAIN_LOOP_HYSTERESIS_THRESHOLD) rdata_q <= hyst_q;
          if (reg_addr == OFS_GAIN_LOOP_MAX_GAIN) rdata_q <= max_q;
          if (reg_addr == OFS_GAIN_LOOP_ATTACK) rdata_q <= attack_q;
          if (reg_addr == OFS_GAIN_LOOP_DECAY) rdata_q <= decay_q;
          if (reg_addr == OFS_NOISE_DEBOUNCE_TIME) rdata_q <= ndb_q;
          if (reg_addr == OFS_SIGNAL_DEBOUNCE_TIME) rdata_q <= sdb_q;
          if (reg_addr == OFS_GAIN_LOOP_READBACK) rdata_q <= {1'b0, agc_gain_q};
        end
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign mic_bias_level = bias_q[1:0];
  assign microphone_gain_amp_muted = gain_ctrl_q[BIT_PGA_MUTE];

  // ----------------------------------------
  // Requested gain and soft stepping
  // ----------------------------------------
  always_comb begin
    if (!pwr_q[BIT_POWER_UP] || gain_ctrl_q[BIT_PGA_MUTE]) begin
      req_gain = 7'h00;
    end else if (loop_en) begin
      req_gain = agc_gain_q;
    end else begin
      req_gain = gain_ctrl_q[6:0];
    end
  end

  assign tick = (tick_cnt_q == 16'h0000);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 16'h0000;
      half_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 16'(SOFTSTEP_CYC - 1) : tick_cnt_q - 16'h0001;
      if (tick) half_q <= ~half_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      applied_q <= 7'h00;
    end else if (ss_mode == SS_OFF || ss_mode == SS_OFF_ALT) begin
      applied_q <= req_gain;
    end else if (tick && (ss_mode == SS_EVERY_TICK || half_q)) begin
      if (applied_q < req_gain) applied_q <= applied_q + 7'h01;
      else if (applied_q > req_gain) applied_q <= applied_q - 7'h01;
    end
  end

  assign applied_gain = applied_q;

  // Powered flag drops only once soft step to mute is done
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powered_q <= 1'b0;
    end else if (pwr_q[BIT_POWER_UP]) begin
      powered_q <= 1'b1;
    end else if (applied_q == 7'h00) begin
      powered_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Input resistance scaling
  // ----------------------------------------
  for (genvar j = 0; j < 3; j++) begin : g_res
    always_comb begin
      unique case (res_q[7-2*j -: 2])
        2'b00: gain_res[j] = {2'b00, applied_q};
        2'b01: gain_res[j] = {2'b00, applied_q} + RES_STEP_HALF_DB;
        default: gain_res[j] = {2'b00, applied_q} - RES_STEP_HALF_DB;
      endcase
    end
  end

  assign mic_effective_gain = gain_res[0];
  assign first_auxiliary_input_gain = gain_res[1];
  assign second_auxiliary_input_gain = gain_res[2];

  // ----------------------------------------
  // Record output, mute and saturation
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rec_q <= '0;
      rec_valid_q <= 1'b0;
      rec_sat_q <= 1'b0;
    end else begin
      rec_valid_q <= sample_valid;
      if (sample_valid) begin
        if (!mute_q[BIT_REC_MUTE]) rec_q <= sample_in;
        rec_sat_q <= (ax >= 17'(FULL_SCALE));
      end
    end
  end

  assign rec_data = rec_q;
  assign rec_valid = rec_valid_q;

  // ----------------------------------------
  // Level estimate
  // ----------------------------------------
  function automatic logic signed [34:0] mul(input logic [15:0] c, input logic signed [16:0] v);
    logic signed [34:0] ce;
    logic signed [34:0] ve;
    ce = 35'(signed'(c));
    ve = 35'(v);
    return ce * ve;
  endfunction : mul

  assign ax = sample_in[SAMPLE_W-1] ? 17'(-$signed(sample_in)) : 17'(sample_in);
  assign acc = mul({coef_q[0], coef_q[1]}, signed'(ax))
             + mul({coef_q[2], coef_q[3]}, signed'({1'b0, xp_q}))
             + mul({coef_q[4], coef_q[5]}, signed'({1'b0, avg_q}));

  always_comb begin
    if (acc[34]) avg_d = 16'h0000;
    else if (acc[33:15] > 19'(FULL_SCALE)) avg_d = FULL_SCALE;
    else avg_d = acc[30:15];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avg_q <= 16'h0000;
      xp_q <= 16'h0000;
    end else if (sample_valid) begin
      avg_q <= avg_d;
      xp_q <= ax[15:0];
    end
  end

  // ----------------------------------------
  // Target and noise levels
  // ----------------------------------------
  always_comb begin
    unique case (loop_q[6:4])
      3'd0: target_lin = 16'h43f4;
      3'd1: target_lin = 16'h32f5;
      3'd2: target_lin = 16'h287a;
      3'd3: target_lin = 16'h2027;
      3'd4: target_lin = 16'h198a;
      3'd5: target_lin = 16'h1216;
      3'd6: target_lin = 16'h0ccd;
      3'd7: target_lin = 16'h0814;
    endcase
  end

  // Threshold steps 2 dB per code from -30 dB, code 0 off
  always_comb begin
    logic [4:0] n;
    logic [15:0] base;
    base = 16'h0000;
    n = hyst_q[5:1] - 5'd1;
    unique case (n % 5'd3)
      5'd0: base = 16'h040c;
      5'd1: base = 16'h0336;
      default: base = 16'h028d;
    endcase
    thr_lin = (hyst_q[5:1] == 5'd0) ? 16'h0000 : base >> (n / 5'd3);
    rel_lin = (hyst_q[7:6] == 2'b00) ? thr_lin : thr_lin + (thr_lin >> (3'd4 - {1'b0, hyst_q[7:6]}));
  end

  // ----------------------------------------
  // Silence detection with debounce
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_NORMAL;
      db_q <= 10'h000;
    end else if (!loop_en) begin
      st_q <= ST_NORMAL;
      db_q <= 10'h000;
    end else if (sample_valid) begin
      unique case (st_q)
        ST_NORMAL: begin
          if (avg_q < thr_lin) begin
            if (db_q >= {5'h00, ndb_q[4:0]}) begin
              st_q <= ST_SILENCE;
              db_q <= 10'h000;
            end else begin
              db_q <= db_q + 10'h001;
            end
          end else begin
            db_q <= 10'h000;
          end
        end
        ST_SILENCE: begin
          if (avg_q > rel_lin) begin
            if (db_q >= {6'h00, sdb_q[3:0]}) begin
              st_q <= ST_NORMAL;
              db_q <= 10'h000;
            end else begin
              db_q <= db_q + 10'h001;
            end
          end else begin
            db_q <= 10'h000;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Loop gain: attack, decay, limit
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      agc_gain_q <= 7'h00;
      rate_cnt_q <= 8'h00;
      loop_sat_q <= 1'b0;
    end else if (sample_valid && loop_en) begin
      loop_sat_q <= (avg_q > target_lin && agc_gain_q == 7'h00)
                 || (avg_q < target_lin && agc_gain_q >= max_q[6:0]);
      if (st_q == ST_SILENCE) begin
        rate_cnt_q <= 8'h00;
        if (agc_gain_q != 7'h00) agc_gain_q <= agc_gain_q - 7'h01;
      end else if (agc_gain_q > max_q[6:0]) begin
        agc_gain_q <= max_q[6:0];
      end else if (avg_q > target_lin) begin
        if (rate_cnt_q >= attack_q) begin
          rate_cnt_q <= 8'h00;
          if (agc_gain_q != 7'h00) agc_gain_q <= agc_gain_q - 7'h01;
        end else begin
          rate_cnt_q <= rate_cnt_q + 8'h01;
        end
      end else if (avg_q < target_lin) begin
        if (rate_cnt_q >= decay_q) begin
          rate_cnt_q <= 8'h00;
          if (agc_gain_q < max_q[6:0]) agc_gain_q <= agc_gain_q + 7'h01;
        end else begin
          rate_cnt_q <= rate_cnt_q + 8'h01;
        end
      end else begin
        rate_cnt_q <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_ramp_step;
    sample_valid && loop_en && st_q == ST_SILENCE && agc_gain_q != 7'h00;
  endsequence

  sequence s_ramp_done;
    ##1 agc_gain_q == $past(agc_gain_q) - 7'h01;
  endsequence

  soft_step_size_a: assert property ((ss_mode == SS_EVERY_TICK || ss_mode == SS_HALF_RATE)
    |=> (applied_q == $past(applied_q) || applied_q == $past(applied_q) + 7'h01
      || applied_q == $past(applied_q) - 7'h01))
    else $error("soft step larger than one code");
  soft_step_tick_a: assert property ((ss_mode == SS_EVERY_TICK) && !tick && $stable(ss_mode)
    |=> $stable(applied_q))
    else $error("applied gain moved off a tick");
  soft_off_jump_a: assert property ((ss_mode == SS_OFF) |=> applied_q == $past(req_gain))
    else $error("gain did not jump with soft step off");
  settled_flag_a: assert property (reg_rd && sel_ctrl && reg_addr == OFS_RECORD_STATUS_FLAGS
    |=> rdata_q[BIT_SETTLED] == ($past(applied_q) == $past(req_gain)))
    else $error("settled flag wrong");
  pga_off_zero_a: assert property (gain_ctrl_q[BIT_PGA_MUTE] |-> req_gain == 7'h00)
    else $error("disabled amplifier not at 0 dB");
  fixed_gain_a: assert property (!loop_en && pwr_q[BIT_POWER_UP] && !gain_ctrl_q[BIT_PGA_MUTE]
    |-> req_gain == gain_ctrl_q[6:0])
    else $error("fixed gain not used");
  mute_hold_a: assert property (mute_q[BIT_REC_MUTE] && $past(mute_q[BIT_REC_MUTE])
    |-> $stable(rec_q))
    else $error("muted output changed");
  silence_ramp_a: assert property (s_ramp_step |-> s_ramp_done)
    else $error("silence ramp not half dB per sample");
  max_limit_a: assert property (sample_valid && loop_en && st_q == ST_NORMAL
    && !(reg_wr && sel_ctrl && reg_addr == OFS_GAIN_LOOP_MAX_GAIN)
    |=> agc_gain_q <= max_q[6:0])
    else $error("loop gain above maximum");
  power_hold_a: assert property (!pwr_q[BIT_POWER_UP] && applied_q != 7'h00 && powered_q
    |=> powered_q)
    else $error("powered flag dropped before soft step done");
  res_scale_a: assert property (res_q[7:6] == 2'b01
    |-> mic_effective_gain == signed'({2'b00, applied_q} + RES_STEP_HALF_DB))
    else $error("resistance scaling wrong");

endmodule : mga_mic_gain_agc_control

// ---- mga_pkg.sv ----
// Package for the microphone gain and gain-loop control block.
// Assumes one 125 MHz clock and an 8-bit register port with pages.
package mga_pkg;

  // ----------------------------------------
  // Clock and soft-step timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SOFTSTEP_NS = 1000;
  localparam int SOFTSTEP_CYC = (SOFTSTEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Pages and register offsets
  // ----------------------------------------
  localparam logic [7:0] PAGE_CTRL = 8'h00;
  localparam logic [7:0] PAGE_ANALOG = 8'h01;
  localparam logic [7:0] PAGE_COEF = 8'h04;
  localparam logic [6:0] OFS_RECORD_STATUS_FLAGS = 7'h24;
  localparam logic [6:0] OFS_RECORD_SATURATION_STATUS = 7'h27;
  localparam logic [6:0] OFS_NOISE_LEVEL_STATUS = 7'h2d;
  localparam logic [6:0] OFS_RECORD_POWER_SOFTSTEP = 7'h51;
  localparam logic [6:0] OFS_RECORD_MUTE = 7'h52;
  localparam logic [6:0] OFS_GAIN_LOOP_ENABLE_TARGET = 7'h56;
  localparam logic [6:0] OFS_GAIN_LOOP_HYSTERESIS_THRESHOLD = 7'h57;
  localparam logic [6:0] OFS_GAIN_LOOP_MAX_GAIN = 7'h58;
  localparam logic [6:0] OFS_GAIN_LOOP_ATTACK = 7'h59;
  localparam logic [6:0] OFS_GAIN_LOOP_DECAY = 7'h5a;
  localparam logic [6:0] OFS_NOISE_DEBOUNCE_TIME = 7'h5b;
  localparam logic [6:0] OFS_SIGNAL_DEBOUNCE_TIME = 7'h5c;
  localparam logic [6:0] OFS_GAIN_LOOP_READBACK = 7'h5d;
  localparam logic [6:0] OFS_MIC_BIAS_CTRL = 7'h2e;
  localparam logic [6:0] OFS_MIC_GAIN_CTRL = 7'h2f;
  localparam logic [6:0] OFS_INPUT_RESISTANCE = 7'h30;
  localparam logic [6:0] OFS_COEF_FIRST = 7'h02;
  localparam int COEF_REGS = 6;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_SETTLED = 7;
  localparam int BIT_POWERED = 6;
  localparam int BIT_LOOP_SAT = 5;
  localparam int BIT_REC_SAT = 3;
  localparam int BIT_ABOVE_NOISE = 6;
  localparam int BIT_PGA_MUTE = 7;
  localparam int BIT_POWER_UP = 7;
  localparam int BIT_REC_MUTE = 7;
  localparam int BIT_LOOP_EN = 7;

  // ----------------------------------------
  // Reset values and gain constants
  // ----------------------------------------
  localparam logic [7:0] RST_MIC_GAIN_CTRL = 8'h80;
  localparam logic [7:0] RST_RECORD_POWER_SOFTSTEP = 8'h00;
  localparam logic [7:0] RST_RECORD_MUTE = 8'h80;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_COEF_HI0 = 8'h7f;
  localparam logic [7:0] RST_COEF_LO0 = 8'hff;
  localparam logic [8:0] RES_STEP_HALF_DB = 9'h00c;
  localparam logic [15:0] FULL_SCALE = 16'h7fff;

  typedef enum logic [1:0] {SS_EVERY_TICK, SS_HALF_RATE, SS_OFF, SS_OFF_ALT} mga_ss_t;

endpackage : mga_pkg

// ---- mga_host_model.sv ----
// Host model for the paged register port of the gain block.
// Assumes the bench supplies the clock and waits out reset first.
`timescale 1ns/1ps
module mga_host_model (
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_page,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_page = 8'h00;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // One-cycle write strobe, released fields inverted
  task automatic wr(input logic [7:0] p, input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_page <= p;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_page <= ~p;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // One-cycle read strobe, answer one cycle later
  task automatic rd(input logic [7:0] p, input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_page <= p;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_page <= ~p;
    reg_addr <= ~a;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask : rd
  // Record power-down, clock kept until powered flag drops
  task automatic power_down(output logic ok);
    logic [7:0] d;
    logic v;
    ok = 1'b0;
    wr(8'h00, 7'h51, 8'h00);
    for (int i = 0; i < 1000 && !ok; i++) begin
      rd(8'h00, 7'h24, d, v);
      ok = v && (d[6] === 1'b0);
    end
  endtask : power_down
endmodule : mga_host_model

// ---- mga_mic_gain_agc_control_tb.sv ----
// Testbench for the microphone gain and gain-loop block.
// Assumes the host model owns the register port; bench drives samples.
`timescale 1ns/1ps
module mga_mic_gain_agc_control_tb;
  import mga_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, rec_valid, muted, rv, ok;
  logic [7:0] reg_page, reg_wdata, reg_rdata, rdat;
  logic [6:0] reg_addr, applied_gain;
  logic [1:0] mic_bias_level;
  logic sample_valid = 1'b0;
  logic signed [15:0] sample_in = 16'sh0000;
  logic signed [15:0] rec_data;
  logic signed [8:0] mic_eff, first_auxiliary_input, second_auxiliary_input, eg;
  int failures = 0;
  int samples_checked = 0;
  int n;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
  always #4 clock = ~clock;
  mga_mic_gain_agc_control dut (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .sample_in(sample_in),
    .rec_data(rec_data), .rec_valid(rec_valid), .mic_bias_level(mic_bias_level),
    .applied_gain(applied_gain), .microphone_gain_amp_muted(muted), .mic_effective_gain(mic_eff),
    .first_auxiliary_input_gain(first_auxiliary_input), .second_auxiliary_input_gain(second_auxiliary_input));
  mga_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic rchk(input logic [7:0] p, input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    host.rd(p, a, rdat, rv);
    `CHK(rv, 1'b1)
    `CHK(rdat & m, e)
  endtask : rchk
  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : settle
  task automatic samp(input logic signed [15:0] x, input int k);
    repeat (k) begin
      @(posedge clock);
      sample_valid <= 1'b1;
      sample_in <= x;
      @(posedge clock);
      sample_valid <= 1'b0;
      sample_in <= ~x;
      #1;
      `CHK(rec_valid, 1'b1)
      repeat (2) @(posedge clock);
    end
  endtask : samp
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK(muted, 1'b1)
    `CHK(applied_gain, 7'h00)
    rchk(8'h01, 7'h2f, 8'hff, 8'h80);
    rchk(8'h00, 7'h51, 8'h83, 8'h00);
    rchk(8'h00, 7'h52, 8'h80, 8'h80);
    rchk(8'h04, 7'h02, 8'hff, 8'h7f);
    rchk(8'h04, 7'h03, 8'hff, 8'hff);
    host.wr(8'h04, 7'h07, 8'h12);
    rchk(8'h04, 7'h07, 8'hff, 8'h12);
    host.wr(8'h04, 7'h07, 8'h00);
    rchk(8'h07, 7'h10, 8'hff, 8'h00);
    $display("Test reset done");
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h01, 7'h2e, 8'(c));
      settle(1);
      `CHK(mic_bias_level, 2'(c))
    end
    host.wr(8'h00, 7'h51, 8'h82);
    host.wr(8'h01, 7'h2f, 8'h77);
    settle(3);
    `CHK(applied_gain, 7'h77)
    host.wr(8'h01, 7'h2f, 8'h0a);
    settle(3);
    `CHK(applied_gain, 7'h0a)
    `CHK(muted, 1'b0)
    rchk(8'h00, 7'h24, 8'hc0, 8'hc0);
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h01, 7'h30, {2'(c), 2'(c), 2'(c), 2'b00});
      settle(1);
      eg = 9'sd10 + ((c == 1) ? 9'sd12 : (c == 0) ? 9'sd0 : -9'sd12);
      `CHK(mic_eff, eg)
      `CHK(first_auxiliary_input, eg)
      `CHK(second_auxiliary_input, eg)
    end
    $display("Test fixed gain done");
    host.wr(8'h00, 7'h51, 8'h80);
    host.wr(8'h01, 7'h2f, 8'h14);
    rchk(8'h00, 7'h24, 8'h80, 8'h00);
    `CHK(applied_gain < 7'h0c, 1'b1)
    for (n = 0; n < 2000 && applied_gain !== 7'h14; n++) settle(1);
    `CHK(applied_gain, 7'h14)
    `CHK(n >= 9 * SOFTSTEP_CYC - 1, 1'b1)
    `CHK(n <= 10 * SOFTSTEP_CYC, 1'b1)
    if (applied_gain !== 7'h14) end_sim;
    rchk(8'h00, 7'h24, 8'h80, 8'h80);
    host.wr(8'h00, 7'h51, 8'h81);
    host.wr(8'h01, 7'h2f, 8'h16);
    for (n = 0; n < 2000 && applied_gain !== 7'h16; n++) settle(1);
    `CHK(applied_gain, 7'h16)
    `CHK(n > 2 * SOFTSTEP_CYC && n <= 4 * SOFTSTEP_CYC, 1'b1)
    host.wr(8'h00, 7'h51, 8'h82);
    host.wr(8'h01, 7'h2f, 8'h94);
    settle(3);
    `CHK(applied_gain, 7'h00)
    $display("Test soft step done");
    samp(16'sh1234, 1);
    `CHK(rec_data, 16'sh0000)
    host.wr(8'h00, 7'h52, 8'h00);
    samp(16'sh1234, 1);
    `CHK(rec_data, 16'sh1234)
    host.wr(8'h00, 7'h52, 8'h80);
    samp(16'sh7fff, 1);
    `CHK(rec_data, 16'sh1234)
    rchk(8'h00, 7'h27, 8'h08, 8'h08);
    $display("Test record path done");
    host.wr(8'h01, 7'h2f, 8'h0a);
    for (int t = 7; t >= 0; t--) begin
      host.wr(8'h00, 7'h56, 8'h80 | 8'(t << 4));
      rchk(8'h00, 7'h56, 8'hf0, 8'h80 | 8'(t << 4));
    end
    host.wr(8'h00, 7'h58, 8'h04);
    samp(16'sh0010, 8);
    rchk(8'h00, 7'h5d, 8'hff, 8'h04);
    rchk(8'h00, 7'h24, 8'h20, 8'h20);
    `CHK(applied_gain, 7'h04)
    rchk(8'h00, 7'h2d, 8'h40, 8'h40);
    host.wr(8'h00, 7'h5d, 8'h7f);
    host.wr(8'h00, 7'h58, 8'h02);
    samp(16'sh0010, 1);
    rchk(8'h00, 7'h5d, 8'hff, 8'h02);
    host.wr(8'h00, 7'h5c, 8'h03);
    host.wr(8'h00, 7'h57, 8'h02); // Top threshold, no hysteresis
    samp(16'sh0010, 3);
    rchk(8'h00, 7'h5d, 8'hff, 8'h00);
    rchk(8'h00, 7'h2d, 8'h40, 8'h00);
    samp(16'sh2000, 3);
    rchk(8'h00, 7'h2d, 8'h40, 8'h00);
    samp(16'sh2000, 2);
    rchk(8'h00, 7'h2d, 8'h40, 8'h40);
    $display("Test gain loop done");
    host.wr(8'h00, 7'h56, 8'h00);
    settle(2);
    `CHK(applied_gain, 7'h0a)
    host.power_down(ok);
    `CHK(ok, 1'b1)
    `CHK(applied_gain, 7'h00)
    $display("Test power down done");
    end_sim;
  end
endmodule : mga_mic_gain_agc_control_tb
